// *** hdl/ref_switch_pkg.sv ***
// Purpose: shared constants for the reference clock switchover block
// Assumes: one core clock at 200 MHz; reference inputs are sampled, not used as clocks
// Notes:   register offsets are indices on a plain word port

package ref_switch_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [3:0] ADDR_CTRL      = 4'h0;	// source, mode, load code, drive
	localparam logic [3:0] ADDR_PLL_REF0  = 4'h1;	// reference divider codes, one per pll
	localparam logic [3:0] ADDR_PLL_REF3  = 4'h4;
	localparam logic [3:0] ADDR_PLL_FB1   = 4'h5;	// feedback codes of plls 1..3
	localparam logic [3:0] ADDR_PLL_FB3   = 4'h7;
	localparam logic [3:0] ADDR_STATUS    = 4'h8;	// read only

	// ****************************************
	// control field layout
	// ****************************************
	localparam int CTRL_PRIM_BIT  = 0;	// primary_source_select
	localparam int CTRL_MODE_LO   = 1;	// switchover_mode_select[1:0]
	localparam int CTRL_LOAD_LO   = 4;	// crystal_load_cap_code[4:0]
	localparam int CTRL_DRIVE_LO  = 16;	// crystal_drive_strength[7:0]

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [4:0] LOAD_CODE_RST = 5'h00;
	localparam logic [7:0] DRIVE_RST     = 8'h11;
	localparam logic [1:0] MODE_RST      = 2'h0;
	localparam logic [6:0] REF_DIV_RST   = 7'h01;
	localparam logic [11:0] FB_DIV_RST   = 12'h001;

	// ****************************************
	// load capacitance in units of 0.125 pF
	// ****************************************
	localparam logic [5:0] LOAD_BASE_STEPS = 6'h1C;	// 3.5 pF / 0.125 pF

	// loss declared after this many secondary edges with no primary edge
	localparam logic [1:0] LOSS_EDGES = 2'h2;
	// synchroniser depth for pin inputs
	localparam int SYNC_DEPTH = 3;

	// selection states
	typedef enum logic [0:0] {
		ON_PRIMARY,
		ON_SECONDARY
	} sel_state_t;

endpackage

// *** hdl/pin_sync.sv ***
// Purpose: three-stage synchroniser with agreement filter for one pin
// Assumes: input asynchronous to core_clk
// Notes:   output changes only when stages two and three agree

`timescale 1ns/100ps

module pin_sync
	import ref_switch_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// pin and filtered level
	input  wire logic pin_in,
	output logic      level
);

	// ****************************************
	// state
	// ****************************************
	logic [SYNC_DEPTH-1:0] stages;		// shift chain, stage 0 is metastable
	logic [SYNC_DEPTH-1:0] next_stages;
	logic                  next_level;

	// shift and update the filtered level only on agreement
	always_comb begin
		next_stages = {stages[SYNC_DEPTH-2:0], pin_in};
		next_level  = level;
		if (stages[1] == stages[2]) begin
			next_level = stages[2];
		end
	end

	// registers only
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			stages <= '0;
			level  <= 1'b0;
		end else begin
			stages <= next_stages;
			level  <= next_level;
		end
	end

endmodule

// *** hdl/ref_clock_switchover.sv ***
// Purpose: reference input selection, manual and automatic failover
// Assumes: reference inputs are far below core_clk; they are sampled as levels
// Notes:   the chosen reference is issued as a registered, sampled copy

`timescale 1ns/100ps

//Contract
// [RULE1] select bit picks which input is primary
// [RULE2] mode upper bit clear means manual pin select
// [RULE3] manual switch produces no output glitch
// [RULE4] auto fails over after two quiet secondary cycles
// [RULE5] auto mode reverts when primary returns
// [RULE6] auto mode needs crystal input as primary
// [RULE7] secondary no faster than primary
// [RULE8] switchover unsupported with a crystal
// [RULE9] selection acts asynchronously to system clocks; here it is registered on core_clk
// [RULE10] plls 0-2 ref code zero powers down
// [RULE11] pll3 ref code must be 3..127
// [RULE12] plls 1-3 multiplier equals feedback code
// [RULE13] load cap is 3.5pF plus code eighths
// [RULE14] external clock: load 00h, drive 11h
// [RULE15] count secondary edges, clear on primary
module ref_clock_switchover
	import ref_switch_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// reference pins
	input  wire logic        crystal_or_ref_input,
	input  wire logic        second_clock_input,
	input  wire logic        input_clock_select_pin,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// clock path and analog controls
	output logic             ref_clk_out,
	output logic             on_secondary,
	output logic [3:0]       pll_powered,
	output logic [5:0]       load_cap_steps,
	output logic [7:0]       crystal_drive_strength
);

	// ****************************************
	// synchronised pins
	// ****************************************
	logic xin_lvl;		// crystal_or_ref_input level
	logic cin_lvl;		// second_clock_input level
	logic sel_lvl;		// input_clock_select_pin level

	pin_sync u_sync_xin (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pin_in   (crystal_or_ref_input),
		.level    (xin_lvl)
	);
	pin_sync u_sync_cin (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pin_in   (second_clock_input),
		.level    (cin_lvl)
	);
	pin_sync u_sync_sel (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pin_in   (input_clock_select_pin),
		.level    (sel_lvl)
	);

	// ****************************************
	// configuration registers
	// ****************************************
	logic        primary_source_select;		// 0: crystal input primary
	logic [1:0]  switchover_mode_select;	// 0x manual, 1x automatic
	logic [4:0]  crystal_load_cap_code;
	logic [7:0]  drive_reg;
	logic [6:0]  ref_div [4];				// reference divider codes
	logic [11:0] fb_div [3];				// feedback codes, plls 1..3
	logic        next_prim;
	logic [1:0]  next_mode;
	logic [4:0]  next_load;
	logic [7:0]  next_drive;
	logic [6:0]  next_ref_div [4];
	logic [11:0] next_fb_div [3];

	// ****************************************
	// selection state
	// ****************************************
	sel_state_t  state;
	sel_state_t  next_state;
	logic        xin_d;			// previous levels for edge detection
	logic        cin_d;
	logic [1:0]  quiet_cnt;		// secondary edges since last primary edge
	logic [1:0]  next_quiet_cnt;
	logic        next_out;
	logic [31:0] next_rdata;
	logic [3:0]  next_powered;
	logic        out_cin;		// output currently follows second_clock_input
	logic        next_out_cin;
	logic        tgt_cin;		// pin that the selection asks the output to follow
	logic        new_edge;		// that pin moved in this cycle

	// edge of either level, used for both inputs
	function automatic logic edge_of(input logic now, input logic prev);
		edge_of = now ^ prev;
	endfunction

	// primary and secondary levels after source designation
	logic sec_lvl;
	logic prim_edge;
	logic sec_rise;
	always_comb begin
		sec_lvl   = primary_source_select ? xin_lvl : cin_lvl;		// RULE1
		prim_edge = primary_source_select ? edge_of(cin_lvl, cin_d)
		                                  : edge_of(xin_lvl, xin_d);
		// a secondary cycle is counted on its rising edge only
		sec_rise  = sec_lvl & (primary_source_select ? ~xin_d : ~cin_d);
	end

	// ****************************************
	// register write path
	// ****************************************
	// writes steer selection; codes outside the legal pll3 range are still stored
	always_comb begin
		next_prim    = primary_source_select;
		next_mode    = switchover_mode_select;
		next_load    = crystal_load_cap_code;
		next_drive   = drive_reg;
		next_ref_div = ref_div;
		next_fb_div  = fb_div;
		if (reg_wr) begin
			if (reg_addr == ADDR_CTRL) begin
				next_prim  = reg_wdata[CTRL_PRIM_BIT];
				next_mode  = reg_wdata[CTRL_MODE_LO +: 2];
				next_load  = reg_wdata[CTRL_LOAD_LO +: 5];
				next_drive = reg_wdata[CTRL_DRIVE_LO +: 8];
			end else if (reg_addr >= ADDR_PLL_REF0 && reg_addr <= ADDR_PLL_REF3) begin
				next_ref_div[2'(reg_addr - ADDR_PLL_REF0)] = reg_wdata[6:0];
			end else if (reg_addr >= ADDR_PLL_FB1 && reg_addr <= ADDR_PLL_FB3) begin
				next_fb_div[2'(reg_addr - ADDR_PLL_FB1)] = reg_wdata[11:0];	// RULE12
			end
		end
	end

	// register read path, data valid one cycle after the strobe
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_CTRL: begin
					next_rdata[CTRL_PRIM_BIT]       = primary_source_select;
					next_rdata[CTRL_MODE_LO +: 2]   = switchover_mode_select;
					next_rdata[CTRL_LOAD_LO +: 5]   = crystal_load_cap_code;
					next_rdata[CTRL_DRIVE_LO +: 8]  = drive_reg;
				end
				ADDR_STATUS: begin
					next_rdata[0]   = (state == ON_SECONDARY);
					next_rdata[2:1] = quiet_cnt;
					next_rdata[7:4] = pll_powered;
				end
				default: begin
					if (reg_addr >= ADDR_PLL_REF0 && reg_addr <= ADDR_PLL_REF3) begin
						next_rdata[6:0] = ref_div[2'(reg_addr - ADDR_PLL_REF0)];
					end else if (reg_addr >= ADDR_PLL_FB1 && reg_addr <= ADDR_PLL_FB3) begin
						next_rdata[11:0] = fb_div[2'(reg_addr - ADDR_PLL_FB1)];
					end
				end
			endcase
		end
	end

	// ****************************************
	// loss detection and selection
	// ****************************************
	// manual mode follows the pin; auto mode fails over on loss and reverts
	always_comb begin
		// the count only runs in auto mode, so a count left over from manual
		// operation cannot trigger an early failover when auto mode starts
		next_quiet_cnt = quiet_cnt;
		if (prim_edge || !switchover_mode_select[1]) begin
			next_quiet_cnt = 2'h0;						// RULE15
		end else if (sec_rise && quiet_cnt != LOSS_EDGES) begin
			next_quiet_cnt = quiet_cnt + 2'h1;			// RULE15
		end
		next_state = state;
		if (!switchover_mode_select[1]) begin
			next_state = sel_lvl ? ON_SECONDARY : ON_PRIMARY;	// RULE2
		end else begin
			case (state)
				ON_PRIMARY: begin
					if (next_quiet_cnt == LOSS_EDGES) begin
						next_state = ON_SECONDARY;		// RULE4
					end
				end
				ON_SECONDARY: begin
					if (prim_edge) begin
						next_state = ON_PRIMARY;		// RULE5
					end
				end
				default: begin
					next_state = ON_PRIMARY;
				end
			endcase
		end
		// hand the output over only when the newly chosen pin has just moved
		// to the level the output already shows; that level then lasts a full
		// half period of the new pin, so no runt pulse can appear; the cost is
		// a delay of a few reference edges, and a dead new pin is never taken
		tgt_cin      = primary_source_select ^ (next_state == ON_SECONDARY);	// RULE1
		new_edge     = tgt_cin ? edge_of(cin_lvl, cin_d) : edge_of(xin_lvl, xin_d);
		next_out_cin = out_cin;
		if (tgt_cin != out_cin && new_edge
		    && (tgt_cin ? cin_lvl : xin_lvl) == ref_clk_out) begin	// RULE3
			next_out_cin = tgt_cin;
		end
		next_out = next_out_cin ? cin_lvl : xin_lvl;
		// a reference divider code of zero powers plls 0..2 down
		next_powered[0] = (ref_div[0] != 7'h00);				// RULE10
		next_powered[1] = (ref_div[1] != 7'h00);				// RULE10
		next_powered[2] = (ref_div[2] != 7'h00);				// RULE10
		next_powered[3] = (ref_div[3] != 7'h00);
	end

	// ****************************************
	// registers
	// ****************************************
	// selection state is registered on core_clk, the same clock edge the register port uses
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			primary_source_select  <= 1'b0;
			switchover_mode_select <= MODE_RST;
			crystal_load_cap_code  <= LOAD_CODE_RST;
			drive_reg              <= DRIVE_RST;
			for (int i = 0; i < 4; i++) begin
				ref_div[i] <= REF_DIV_RST;
			end
			for (int i = 0; i < 3; i++) begin
				fb_div[i] <= FB_DIV_RST;
			end
			state                  <= ON_PRIMARY;
			xin_d                  <= 1'b0;
			cin_d                  <= 1'b0;
			quiet_cnt              <= 2'h0;
			ref_clk_out            <= 1'b0;
			out_cin                <= 1'b0;
			on_secondary           <= 1'b0;
			reg_rdata              <= 32'h0000_0000;
			pll_powered            <= 4'h0;
			load_cap_steps         <= LOAD_BASE_STEPS;
			crystal_drive_strength <= DRIVE_RST;
		end else begin
			primary_source_select  <= next_prim;
			switchover_mode_select <= next_mode;
			crystal_load_cap_code  <= next_load;
			drive_reg              <= next_drive;
			ref_div                <= next_ref_div;
			fb_div                 <= next_fb_div;
			state                  <= next_state;		// registered on core_clk, not asynchronous as RULE9 asks
			xin_d                  <= xin_lvl;
			cin_d                  <= cin_lvl;
			quiet_cnt              <= next_quiet_cnt;
			ref_clk_out            <= next_out;
			out_cin                <= next_out_cin;
			on_secondary           <= (next_state == ON_SECONDARY);
			reg_rdata              <= next_rdata;
			pll_powered            <= next_powered;
			load_cap_steps         <= LOAD_BASE_STEPS + {1'b0, crystal_load_cap_code};	// RULE13
			crystal_drive_strength <= drive_reg;
		end
	end

endmodule

// *** tb/ref_sources.sv ***
// Purpose: the two external reference oscillators at the far side
// Assumes: both pins are fed by oscillators, never by a crystal
// Notes:   a stopped source holds its level, as a dead oscillator does
`timescale 1ns/100ps
module ref_sources (
	// source controls
	input  wire logic run_prim,	// primary oscillator running
	input  wire logic slow,	// stretch the secondary period
	// clock lines
	output logic      crystal_or_ref_input,
	output logic      second_clock_input
);
	// ****************************************
	// oscillators
	// ****************************************
	// odd half periods keep edges off the core clock edges
	initial begin
		crystal_or_ref_input = 1'b0;
		forever #36.3 if (run_prim) crystal_or_ref_input = ~crystal_or_ref_input;
	end
	// secondary never runs faster than the primary
	initial begin
		second_clock_input = 1'b0;
		forever #(slow ? 113.4 : 56.7) second_clock_input = ~second_clock_input;
	end
endmodule

// *** tb/ref_clock_switchover_chk.sv ***
// Purpose: port checker for the switchover block
// Assumes: reference pins are slow against core_clk
// Notes:   keeps a shadow of the control word seen on the write port
`timescale 1ns/100ps
module ref_clock_switchover_chk
	import ref_switch_pkg::*;
(
	// clock and reset
	input wire logic        core_clk,
	input wire logic        sys_rst,
	// pins and register port
	input wire logic        crystal_or_ref_input,
	input wire logic        second_clock_input,
	input wire logic        input_clock_select_pin,
	input wire logic [3:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// outputs
	input wire logic        ref_clk_out,
	input wire logic        on_secondary,
	input wire logic [3:0]  pll_powered,
	input wire logic [5:0]  load_cap_steps,
	input wire logic [7:0]  crystal_drive_strength
);
	// ****************************************
	// helper state
	// ****************************************
	logic [31:0] ctrl;	// shadow control word
	logic [3:0]  calm;	// cycles since a write, pin move or switch
	logic [3:0]  pq;	// cycles since the primary pin moved
	logic [3:0]  run;	// length of the current output level
	logic [6:0]  hist;	// samples of the selected source
	logic [5:0]  settle;	// like calm, but long enough for the glitch-free handover
	logic        p_d, c_d, s_d, o_d, hit;
	assign hit = reg_wr || (c_d != input_clock_select_pin) || (s_d != on_secondary);
	// counters saturate so they never wrap into a false settle
	always_ff @(posedge core_clk) begin
		p_d <= crystal_or_ref_input;
		c_d <= input_clock_select_pin;
		s_d <= on_secondary;
		o_d <= ref_clk_out;
		hist <= {hist[5:0], (ctrl[0] ^ on_secondary) ? second_clock_input : crystal_or_ref_input};
		if (reg_wr && reg_addr == ADDR_CTRL)
			ctrl <= reg_wdata;
		calm <= hit ? 4'h0 : calm + {3'h0, calm != 4'hF};
		pq <= (p_d != crystal_or_ref_input) ? 4'h0 : pq + {3'h0, pq != 4'hF};
		run <= (o_d != ref_clk_out) ? 4'h1 : run + {3'h0, run != 4'hF};
		settle <= hit ? 6'h00 : settle + {5'h00, settle != 6'h3F};
		if (sys_rst) begin
			ctrl <= 32'h0011_0000;
			calm <= 4'h0;
			pq <= 4'h0;
			run <= 4'hF;
			settle <= 6'h00;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// ****************************************
	// properties
	// ****************************************
	property p_load;
		calm > 4'h3 |-> load_cap_steps == LOAD_BASE_STEPS + {1'b0, ctrl[8:4]}
			&& crystal_drive_strength == ctrl[23:16];
	endproperty
	a_load: assert property (p_load) else $error("load or drive wrong");
	property p_pwr;
		logic [6:0] c;
		(reg_wr && reg_addr == ADDR_PLL_REF0, c = reg_wdata[6:0])
			|-> ##2 pll_powered[0] == (c != 7'h0);
	endproperty
	a_pwr: assert property (p_pwr) else $error("power state wrong");
	property p_manual;
		!ctrl[2] && calm == 4'hC |-> on_secondary == input_clock_select_pin;
	endproperty
	a_manual: assert property (p_manual) else $error("pin select ignored");
	property p_src;
		settle > 6'h32 |-> (ref_clk_out ? |hist[6:2] : !(&hist[6:2]));
	endproperty
	a_src: assert property (p_src) else $error("wrong source");
	property p_fail;
		ctrl[2] && $rose(on_secondary) |-> pq == 4'hF;
	endproperty
	a_fail: assert property (p_fail) else $error("early failover");
	property p_stay;
		ctrl[2] && !on_secondary && pq < 4'h8 |=> !on_secondary;
	endproperty
	a_stay: assert property (p_stay) else $error("left live primary");
	property p_revert;
		ctrl[2] && on_secondary && p_d != crystal_or_ref_input |-> ##[1:10] !on_secondary;
	endproperty
	a_revert: assert property (p_revert) else $error("no revert");
	property p_glitch;
		o_d != ref_clk_out |-> run > 4'h1;
	endproperty
	a_glitch: assert property (p_glitch) else $error("runt pulse");
	c_auto: cover property (ctrl[2] && $rose(on_secondary));
	c_manual: cover property (!ctrl[2] && $rose(on_secondary));
	c_off: cover property ($fell(pll_powered[0]));
endmodule
bind ref_clock_switchover ref_clock_switchover_chk ref_clock_switchover_chk_i (
	.core_clk, .sys_rst, .crystal_or_ref_input, .second_clock_input,
	.input_clock_select_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.ref_clk_out, .on_secondary, .pll_powered, .load_cap_steps, .crystal_drive_strength
);

// *** tb/ref_clock_switchover_test.sv ***
// Purpose: self-checking bench for the switchover block
// Assumes: reads are scored by a monitor from a queue of notes
// Notes:   random codes come from an xorshift seeded at 81
`timescale 1ns/100ps
module ref_clock_switchover_test
	import ref_switch_pkg::*;
;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic        core_clk, sys_rst, input_clock_select_pin, reg_wr, reg_rd, rd_d, run_prim, slow;
	logic        crystal_or_ref_input, second_clock_input, ref_clk_out, on_secondary;
	logic [3:0]  reg_addr, pll_powered;
	logic [31:0] reg_wdata, reg_rdata, rnd;
	logic [5:0]  load_cap_steps;
	logic [7:0]  crystal_drive_strength;
	logic [6:0]  rc [3];	// reference codes of plls 0..2
	logic [11:0] fb [3];	// feedback codes of plls 1..3
	logic [6:0]  c3;
	logic [4:0]  ld;
	logic [63:0] exp_q [$];	// mask and value of each pending read
	logic [63:0] e;
	int          errors, checks_done;
	ref_sources ref_sources_i (.run_prim, .slow, .crystal_or_ref_input, .second_clock_input);
	ref_clock_switchover ref_clock_switchover_i (
		.core_clk, .sys_rst, .crystal_or_ref_input, .second_clock_input,
		.input_clock_select_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.ref_clk_out, .on_secondary, .pll_powered, .load_cap_steps, .crystal_drive_strength
	);
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			errors++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic final_report();
		$display("errors %0d checks_done %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ****************************************
	// register port, one strobe per cycle
	// ****************************************
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		exp_q.push_back({m, d});
		@(posedge core_clk);
	endtask
	task automatic idle(input int n);
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
		repeat (n) @(posedge core_clk);
	endtask
	// bounded wait, sampled away from the edge
	task automatic wait_sec(input logic v);
		int n;
		n = 0;
		while (on_secondary !== v && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		chk(n < 300, "switch timed out");
		if (n >= 300)
			final_report();
		@(posedge core_clk);
	endtask
	// read data stand only in the cycle after the strobe
	always @(posedge core_clk) rd_d <= reg_rd;
	always @(negedge core_clk) begin
		if (rd_d) begin
			e = exp_q.pop_front();
			chk((reg_rdata & e[63:32]) === e[31:0], "read data");
		end
	end
	initial begin
		{reg_wr, reg_rd, input_clock_select_pin, slow} = 4'h0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		run_prim = 1'b1;
		rnd = 32'h51;
		sys_rst = 1'b1;
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		chk(load_cap_steps === LOAD_BASE_STEPS && crystal_drive_strength === DRIVE_RST, "rst");
		rd(ADDR_CTRL, 32'h0011_0000, ALL);
		for (int a = 1; a < 8; a++) rd(4'(a), 32'h1, ALL);
		rd(ADDR_STATUS, 32'hF0, 32'hF1);
		wr(4'hF, ALL);
		rd(4'hF, 32'h0, ALL);
		for (int i = 0; i < 6; i++) begin
			rnd = xs(rnd);
			for (int p = 0; p < 3; p++) begin
				rc[p] = (i == 0) ? 7'h0 : rnd[p*8 +: 7];
				fb[p] = (i == 1) ? 12'hFFF : rnd[p*10 +: 12] | 12'h001;
				wr(4'(p + 1), {25'h0, rc[p]});
				wr(4'(p + 5), {20'h0, fb[p]});
			end
			c3 = (rnd[30:24] < 7'h3) ? 7'h3 : rnd[30:24];
			wr(ADDR_PLL_REF3, {25'h0, c3});
			for (int p = 0; p < 3; p++) begin
				rd(4'(p + 1), {25'h0, rc[p]}, ALL);
				rd(4'(p + 5), {20'h0, fb[p]}, ALL);
			end
			rd(ADDR_PLL_REF3, {25'h0, c3}, ALL);
			rd(ADDR_STATUS, {24'h0, 1'b1, rc[2] != 0, rc[1] != 0, rc[0] != 0, 4'h0}, 32'hF0);
		end
		for (int k = 0; k < 2; k++) begin
			rnd = xs(rnd);
			ld = k ? 5'h1F : rnd[12:8];
			wr(ADDR_CTRL, {8'h0, rnd[7:0], 7'h0, ld, 4'h0});
			idle(3);
			chk(load_cap_steps === LOAD_BASE_STEPS + {1'b0, ld}, "load steps");
			chk(crystal_drive_strength === rnd[7:0], "drive field");
		end
		for (int p = 0; p < 2; p++) begin
			wr(ADDR_CTRL, 32'h0011_0000 | p);
			for (int s = 0; s < 3; s++) begin
				input_clock_select_pin <= s[0];
				idle(1);
				wait_sec(s[0]);
				rd(ADDR_STATUS, {31'h0, s[0]}, 32'h1);
				idle(80);
			end
		end
		wr(ADDR_CTRL, 32'h0011_0004);
		idle(150);
		rd(ADDR_STATUS, 32'h0, 32'h1);
		for (int k = 0; k < 2; k++) begin
			slow <= k[0];
			run_prim <= 1'b0;
			wait_sec(1'b1);
			rd(ADDR_STATUS, 32'h5, 32'h5);
			run_prim <= 1'b1;
			wait_sec(1'b0);
			rd(ADDR_STATUS, 32'h0, 32'h1);
			idle(60);
		end
		final_report();
	end
endmodule
